// ===== pot_pkg.sv
// Constants shared by the wiper control slave and its pin sampler
package pot_pkg;
	// Register addresses
	localparam logic [4:0] WIPER_ADDR     = 5'h00;
	localparam logic [4:0] WIPER_ADDR_ALT = 5'h01;
	localparam logic [4:0] CTRL_ADDR      = 5'h10;
	// Reset values
	localparam logic [7:0] WIPER_RESET    = 8'h80;
	localparam logic [7:0] CTRL_RESET     = 8'h40;
	// Access control register fields
	localparam int         SHUTDOWN_N_POS = 6;
	localparam int         ODRAIN_POS     = 1;
	localparam logic [7:0] CTRL_WR_MASK   = 8'h42;
	// Instruction byte layout and opcodes
	localparam int         OPC_MSB        = 7;
	localparam int         OPC_LSB        = 5;
	localparam int         ADDR_MSB       = 4;
	localparam logic [2:0] OPC_NOP        = 3'h0;
	localparam logic [2:0] OPC_CTRL_RD    = 3'h1;
	localparam logic [2:0] OPC_CTRL_WR    = 3'h3;
	localparam logic [2:0] OPC_REG_RD     = 3'h4;
	localparam logic [2:0] OPC_REG_WR     = 3'h6;
	localparam logic [2:0] ECHO_CODE      = 3'h7;
	// Byte positions inside a frame
	localparam logic [2:0] BYTE_INSTR     = 3'h0;
	localparam logic [2:0] BYTE_DATA      = 3'h1;
	localparam logic [2:0] BYTE_ECHO      = 3'h2;
	localparam logic [2:0] BYTE_VALUE     = 3'h3;
	localparam logic [2:0] BYTE_SAT       = 3'h4;
	// Timing
	localparam int         CLK_FREQ_MHZ   = 100;
	localparam int         SETTLE_TIME_NS = 1000;
	localparam int         SETTLE_CYCLES  =
		(SETTLE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int         SYNC_STAGES    = 3;
endpackage : pot_pkg

// ===== spi_host_model.sv
// Behavioural mode 0 host that masters the serial link
`timescale 1ns/1ps
module spi_host_model (
	// Pacing clock
	input  wire logic clk,
	// Link pins
	output logic      sck,
	output logic      cs_n,
	output logic      sdi,
	input  wire logic output_drive_select_bit
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b0; // Low at power-up: first frame has no fall
		sdi = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge clk);
		#1;
	endtask : half
	task automatic xfer(input logic [31:0] tx, input int nbits,
		output logic [31:0] rx);
		rx = 32'h0;
		if (cs_n) begin
			cs_n = 1'b0;
			half();
		end
		for (int i = 0; i < nbits; i++) begin
			sdi = tx[31 - i];
			half();
			sck = 1'b1;
			half();
			// Slave answers late, so sample at the end of the high phase
			rx = {rx[30:0], output_drive_select_bit};
			sck = 1'b0;
		end
	endtask : xfer
	task automatic finish_frame();
		half();
		cs_n = 1'b1;
		repeat (20) @(posedge clk);
		#1;
	endtask : finish_frame
endmodule : spi_host_model

// ===== spi_pin_sampler.sv
// Three-stage sampler for the serial pins with agreement filter
`timescale 1ns/1ps
module spi_pin_sampler
	import pot_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Raw pins
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic sdi,
	// Sampled view
	spi_pins_if.src   pins
);
	// Reset to idle levels: clock low, select high, data low
	localparam logic [2:0] RST_LVL = 3'h2;
	localparam int         N_PINS  = 3;

	logic [2:0] raw;
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic [2:0] s3_q;
	logic [2:0] lvl_q;
	logic [2:0] lvl_prev_q;
	logic [2:0] agree;

	assign raw   = {sdi, cs_n, sck};
	assign agree = ~(s2_q ^ s3_q);

	genvar i;
	generate
		for (i = 0; i < N_PINS; i++) begin : g_pin
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					s1_q[i]       <= RST_LVL[i];
					s2_q[i]       <= RST_LVL[i];
					s3_q[i]       <= RST_LVL[i];
					lvl_q[i]      <= RST_LVL[i];
					lvl_prev_q[i] <= RST_LVL[i];
				end else begin
					s1_q[i]       <= raw[i];
					s2_q[i]       <= s1_q[i];
					s3_q[i]       <= s2_q[i];
					// A change counts only once stages two and three agree
					if (agree[i])
						lvl_q[i] <= s3_q[i];
					lvl_prev_q[i] <= lvl_q[i];
				end
			end
		end
	endgenerate

	assign pins.sck_rise = lvl_q[0] & ~lvl_prev_q[0];
	assign pins.sck_fall = ~lvl_q[0] & lvl_prev_q[0];
	assign pins.cs_n_lvl = lvl_q[1];
	assign pins.cs_fall  = ~lvl_q[1] & lvl_prev_q[1];
	assign pins.cs_rise  = lvl_q[1] & ~lvl_prev_q[1];
	assign pins.sdi_lvl  = lvl_q[2];
endmodule : spi_pin_sampler

// ===== spi_pins_if.sv
// Sampled serial pin levels and edge pulses between sampler and core
`timescale 1ns/1ps
interface spi_pins_if;
	logic sck_rise;
	logic sck_fall;
	logic cs_n_lvl;
	logic cs_fall;
	logic cs_rise;
	logic sdi_lvl;

	modport src (
		output sck_rise,
		output sck_fall,
		output cs_n_lvl,
		output cs_fall,
		output cs_rise,
		output sdi_lvl
	);
	modport dst (
		input sck_rise,
		input sck_fall,
		input cs_n_lvl,
		input cs_fall,
		input cs_rise,
		input sdi_lvl
	);
endinterface : spi_pins_if

// ===== spi_wiper_control_slave.sv
// Serial control slave for a 256-tap potentiometer wiper
// What this block does
// - Hold 8-bit wiper code, 00h low end.
// - Wiper code resets to mid-scale 80h.
// - Wiper at address 0, control at 10h.
// - Control bit 1 selects open-drain serial output.
// - Control bit 6 low forces shutdown.
// - Shutdown keeps code; resume after settling.
// - Sample input on rise, change output on fall.
// - Device is slave only, never drives clock/select.
// - Bytes shift most significant bit first.
// - First byte: opcode 7..5, address 4..0.
// - Address 0 or 1 wiper, 10000 control.
// - Decode nop, control read/write, addressed read/write.
// - Writes execute on select rising edge.
// - Read frame returns echo, then register value.
// - Output released while select high.
// - Echo is 111 followed by read address.
`timescale 1ns/1ps
module spi_wiper_control_slave
	import pot_pkg::*;
#(
	parameter int SETTLE_CYC = SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Serial pins; sck, cs_n and sdi driven by the host, sdo_o and sdo_oe by the slave
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       sdi,
	output logic            sdo_o,
	output logic            sdo_oe,
	// Potentiometer array control
	output logic [7:0]      wiper_code,
	output logic [7:0]      tap_code,
	output logic            array_open,
	output logic            wiper_to_low
);
	typedef enum logic [1:0] {UNARMED, STANDBY, ACTIVE} frame_st_t;
	typedef enum logic [1:0] {RUN, OFF, SETTLE} pwr_st_t;

	// Cycles after reset before the sampler shows real pin levels
	localparam int ARM_CYC = SYNC_STAGES + 2;

	spi_pins_if pins ();

	spi_pin_sampler u_sampler (
		.clk  (clk),
		.rstn (rstn),
		.sck  (sck),
		.cs_n (cs_n),
		.sdi  (sdi),
		.pins (pins.src)
	);

	// Address decode, used for reads and writes
	function automatic logic is_wiper_addr(input logic [4:0] a);
		return (a == WIPER_ADDR) || (a == WIPER_ADDR_ALT);
	endfunction : is_wiper_addr

	function automatic logic is_ctrl_addr(input logic [4:0] a);
		return a == CTRL_ADDR;
	endfunction : is_ctrl_addr

	frame_st_t   frame_q;
	frame_st_t   frame_d;
	pwr_st_t     pwr_q;
	pwr_st_t     pwr_d;
	logic [2:0]  bit_cnt_q;
	logic [2:0]  byte_cnt_q;
	logic [7:0]  shift_in_q;
	logic [7:0]  instr_q;
	logic [7:0]  data_q;
	logic [7:0]  shift_out_q;
	logic [7:0]  wiper_q;
	logic [7:0]  ctrl_q;
	logic [15:0] settle_q;
	logic        sdo_o_q;
	logic        sdo_oe_q;
	logic [7:0]  tap_q;
	logic        open_q;
	logic        low_q;
	logic [2:0]  arm_cnt_q;

	// Decode and selection nets
	logic        armed;
	logic        active;
	logic        bit_rise;
	logic        bit_fall;
	logic [7:0]  byte_in;
	logic        byte_done;
	logic [2:0]  opcode;
	logic [4:0]  addr;
	logic        op_ctrl_rd;
	logic        op_ctrl_wr;
	logic        op_reg_rd;
	logic        op_reg_wr;
	logic        is_read;
	logic [4:0]  rd_addr;
	logic [7:0]  echo_byte;
	logic [7:0]  ctrl_view;
	logic [7:0]  rd_value;
	logic        load_echo;
	logic        load_val;
	logic        wr_ok;
	logic        wr_wiper;
	logic        wr_ctrl;
	logic        odrain;
	logic        cur_bit;
	logic        shutdown_req;

	// Byte assembly and instruction fields
	assign active    = (frame_q == ACTIVE);
	assign bit_rise  = active & pins.sck_rise;
	assign bit_fall  = active & pins.sck_fall;
	assign byte_in   = {shift_in_q[6:0], pins.sdi_lvl};
	assign byte_done = bit_rise & (bit_cnt_q == 3'h7);
	assign opcode    = instr_q[OPC_MSB:OPC_LSB];
	assign addr      = instr_q[ADDR_MSB:0];

	// Opcode decode
	assign op_ctrl_rd = (opcode == OPC_CTRL_RD);
	assign op_ctrl_wr = (opcode == OPC_CTRL_WR);
	assign op_reg_rd  = (opcode == OPC_REG_RD);
	assign op_reg_wr  = (opcode == OPC_REG_WR);
	assign is_read    = op_ctrl_rd | op_reg_rd;

	// Read path: echo address and selected value
	assign rd_addr   = op_ctrl_rd ? CTRL_ADDR : addr;
	assign echo_byte = {ECHO_CODE, rd_addr};
	assign ctrl_view = ctrl_q & CTRL_WR_MASK;
	assign rd_value  = is_wiper_addr(rd_addr) ? wiper_q :
	                   is_ctrl_addr(rd_addr)  ? ctrl_view : 8'h00;
	assign load_echo = bit_fall & (bit_cnt_q == 3'h0) &
	                   (byte_cnt_q == BYTE_ECHO) & is_read;
	assign load_val  = bit_fall & (bit_cnt_q == 3'h0) &
	                   (byte_cnt_q == BYTE_VALUE) & is_read;

	// Write path, only with a full data byte received
	assign wr_ok    = active & pins.cs_rise &
	                  (byte_cnt_q >= BYTE_VALUE - 3'h1);
	assign wr_wiper = wr_ok & op_reg_wr & is_wiper_addr(addr);
	assign wr_ctrl  = wr_ok & (op_ctrl_wr |
	                  (op_reg_wr & is_ctrl_addr(addr)));

	// Pin drive for the serial output and the shutdown request
	assign odrain       = ctrl_q[ODRAIN_POS];
	assign cur_bit      = shift_out_q[7];
	assign shutdown_req = ~ctrl_q[SHUTDOWN_N_POS];

	// Power-up arming: the sampler leaves reset at the idle select
	// level, so a select already low at release looks like a fall.
	// Edges are ignored until the stages hold real pin levels.
	assign armed = (arm_cnt_q == 3'(ARM_CYC));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			arm_cnt_q <= 3'h0;
		else if (!armed)
			arm_cnt_q <= arm_cnt_q + 3'h1;
	end

	// Frame sequencing; frames count only after a select fall
	always_comb begin
		frame_d = frame_q;
		case (frame_q)
			UNARMED: if (pins.cs_fall && armed) frame_d = ACTIVE;
			STANDBY: if (pins.cs_fall) frame_d = ACTIVE;
			ACTIVE:  if (pins.cs_n_lvl) frame_d = STANDBY;
			default: frame_d = UNARMED;
		endcase
	end

	// Shutdown sequencing with settling before the wiper reconnects
	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			RUN:     if (shutdown_req) pwr_d = OFF;
			OFF:     if (!shutdown_req) pwr_d = SETTLE;
			SETTLE: begin
				if (shutdown_req)
					pwr_d = OFF;
				else if (settle_q == 16'(SETTLE_CYC - 1))
					pwr_d = RUN;
			end
			default: pwr_d = RUN;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			frame_q <= UNARMED;
			pwr_q   <= RUN;
		end else begin
			frame_q <= frame_d;
			pwr_q   <= pwr_d;
		end
	end

	// Bit and byte counters, cleared at each frame start
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_q  <= 3'h0;
			byte_cnt_q <= 3'h0;
		end else if (pins.cs_fall) begin
			bit_cnt_q  <= 3'h0;
			byte_cnt_q <= 3'h0;
		end else if (bit_rise) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			if (byte_done && byte_cnt_q != BYTE_SAT)
				byte_cnt_q <= byte_cnt_q + 3'h1;
		end
	end

	// Input shifting on rising clock edges
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shift_in_q <= 8'h00;
			instr_q    <= 8'h00;
			data_q     <= 8'h00;
		end else if (bit_rise) begin
			shift_in_q <= byte_in;
			if (byte_done && byte_cnt_q == BYTE_INSTR)
				instr_q <= byte_in;
			if (byte_done && byte_cnt_q == BYTE_DATA)
				data_q <= byte_in;
		end
	end

	// Output shifting on falling clock edges; mode 0 idles low,
	// so the first fall after a byte presents the next MSB
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shift_out_q <= 8'h00;
		end else if (pins.cs_fall) begin
			shift_out_q <= 8'h00;
		end else if (load_echo) begin
			shift_out_q <= echo_byte;
		end else if (load_val) begin
			shift_out_q <= rd_value;
		end else if (bit_fall && bit_cnt_q != 3'h0) begin
			shift_out_q <= {shift_out_q[6:0], 1'b0};
		end
	end

	// Registers update only when select rises after a full data byte
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wiper_q <= WIPER_RESET;
			ctrl_q  <= CTRL_RESET;
		end else begin
			if (wr_wiper)
				wiper_q <= data_q;
			// Reserved bits masked on the way in and on readback
			if (wr_ctrl)
				ctrl_q <= data_q & CTRL_WR_MASK;
		end
	end

	// Settling counter for leaving shutdown
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			settle_q <= 16'h0000;
		else if (pwr_q == SETTLE)
			settle_q <= settle_q + 16'h0001;
		else
			settle_q <= 16'h0000;
	end

	// Serial output drive; released whenever the frame is not live
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sdo_o_q  <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else if (frame_q != ACTIVE || pins.cs_n_lvl) begin
			sdo_o_q  <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else if (odrain) begin
			// Open drain only pulls low; the pull-up makes the one
			sdo_o_q  <= 1'b0;
			sdo_oe_q <= ~cur_bit;
		end else begin
			sdo_o_q  <= cur_bit;
			sdo_oe_q <= 1'b1;
		end
	end

	// Array control; stored code untouched while shut down
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tap_q  <= WIPER_RESET;
			open_q <= 1'b0;
			low_q  <= 1'b0;
		end else if (pwr_q == RUN && !shutdown_req) begin
			tap_q  <= wiper_q;
			open_q <= 1'b0;
			low_q  <= 1'b0;
		end else begin
			tap_q  <= 8'h00;
			open_q <= 1'b1;
			low_q  <= 1'b1;
		end
	end

	assign sdo_o        = sdo_o_q;
	assign sdo_oe       = sdo_oe_q;
	assign wiper_code   = wiper_q;
	assign tap_code     = tap_q;
	assign array_open   = open_q;
	assign wiper_to_low = low_q;
endmodule : spi_wiper_control_slave

// ===== spi_wiper_control_slave_assertions.sv
// Port-level checks for the wiper control slave
`timescale 1ns/1ps
module spi_wiper_control_slave_assertions #(
	parameter int SETTLE_CYC = 3
) (
	// Clock and reset
	input logic       clk,
	input logic       rstn,
	// Serial pins
	input logic       sck,
	input logic       cs_n,
	input logic       sdi,
	input logic       sdo_o,
	input logic       sdo_oe,
	// Array control
	input logic [7:0] wiper_code,
	input logic [7:0] tap_code,
	input logic       array_open,
	input logic       wiper_to_low
);
	// Sampler and settle latency, with margin
	localparam int RESUME_MAX = SETTLE_CYC + 8;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence idle_s; cs_n [*8]; endsequence
	sequence live_s; !cs_n [*8]; endsequence
	sequence shut_in_s; $rose(array_open); endsequence
	AST_OE_IDLE: assert property (idle_s |-> !sdo_oe)
		else $error("sdo driven while deselected");
	AST_NO_MID_WRITE: assert property (live_s |-> $stable(wiper_code))
		else $error("wiper changed inside a frame");
	AST_RESET_VAL: assert property ($rose(rstn) |->
		wiper_code == 8'h80 && tap_code == 8'h80 && !array_open)
		else $error("bad values after reset");
	AST_SHUT_PAIR: assert property (array_open == wiper_to_low)
		else $error("shutdown outputs disagree");
	AST_SHUT_TAP: assert property (
		shut_in_s |-> ##[0:2] tap_code == 8'h00)
		else $error("tap not parked in shutdown");
	AST_SHUT_KEEP: assert property (shut_in_s |-> $stable(wiper_code))
		else $error("wiper lost on shutdown");
	AST_RESUME: assert property ($fell(array_open) |->
		##[0:RESUME_MAX] tap_code == wiper_code)
		else $error("tap not restored after shutdown");
	AST_TAP_FOLLOW: assert property (
		$changed(wiper_code) && !array_open |->
		##[1:2] tap_code == wiper_code)
		else $error("tap does not follow wiper");
endmodule : spi_wiper_control_slave_assertions

bind spi_wiper_control_slave spi_wiper_control_slave_assertions #(
	.SETTLE_CYC(SETTLE_CYC)
) u_chk (
	.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .sdi(sdi),
	.sdo_o(sdo_o), .sdo_oe(sdo_oe), .wiper_code(wiper_code),
	.tap_code(tap_code), .array_open(array_open),
	.wiper_to_low(wiper_to_low)
);

// ===== spi_wiper_control_slave_tb.sv
// Self-checking bench for the wiper control slave
`timescale 1ns/1ps
module spi_wiper_control_slave_tb;
	import pot_pkg::*;
	localparam int SETTLE = 3;
	logic       clk, rstn, sck, cs_n, sdi, sdo_o, sdo_oe, sdo_w;
	logic       array_open, wiper_to_low, od_q, sdo_last;
	logic [7:0] wiper_code, tap_code, rd_e, rd_v;
	logic [31:0] rx;
	int         n_errors, tests_run;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Undriven line: pull-up in open-drain, else inverse of last bit
	assign sdo_w = sdo_oe ? sdo_o : (od_q ? 1'b1 : ~sdo_last);
	always @(posedge clk) if (sdo_oe) sdo_last <= sdo_o;
	spi_wiper_control_slave #(.SETTLE_CYC(SETTLE)) DUT (
		.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .sdi(sdi),
		.sdo_o(sdo_o), .sdo_oe(sdo_oe), .wiper_code(wiper_code),
		.tap_code(tap_code), .array_open(array_open),
		.wiper_to_low(wiper_to_low));
	spi_host_model host (.clk(clk), .sck(sck), .cs_n(cs_n), .sdi(sdi),
		.output_drive_select_bit(sdo_w));
	task automatic chk(input string what, input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] instr, data);
		host.xfer({instr, data, 16'h0000}, 16, rx);
		host.finish_frame();
	endtask : wr
	task automatic rd(input logic [7:0] instr);
		host.xfer({instr, 24'h000000}, 32, rx);
		host.finish_frame();
		rd_e = rx[15:8];
		rd_v = rx[7:0];
	endtask : rd
	task automatic t_unarmed();
		wr(8'hc0, 8'h11);
		chk("wiper", wiper_code, WIPER_RESET);
		chk("tap", tap_code, WIPER_RESET);
		$display("unarmed done");
	endtask : t_unarmed
	task automatic t_wiper();
		rd(8'h80);
		chk("echo", rd_e, 8'he0);
		chk("value", rd_v, WIPER_RESET);
		host.xfer({8'hc0, 8'h1c, 16'h0000}, 16, rx);
		repeat (10) @(posedge clk);
		#1;
		chk("early", wiper_code, WIPER_RESET);
		host.finish_frame();
		chk("wiper", wiper_code, 8'h1c);
		chk("tap", tap_code, 8'h1c);
		wr(8'hc1, 8'hff);
		rd(8'h81);
		chk("echo1", rd_e, 8'he1);
		chk("value1", rd_v, 8'hff);
		$display("wiper done");
	endtask : t_wiper
	task automatic t_ctrl();
		rd(8'h27);
		chk("ctrl echo", rd_e, 8'hf0);
		chk("ctrl", rd_v, CTRL_RESET);
		wr(8'h65, 8'hff);
		od_q = 1'b1;
		rd(8'h90);
		chk("ctrl od", rd_v, 8'h42);
		wr(8'hd0, 8'h00);
		od_q = 1'b0;
		chk("open", {7'h00, array_open}, 8'h01);
		chk("low", {7'h00, wiper_to_low}, 8'h01);
		chk("tap off", tap_code, 8'h00);
		chk("kept", wiper_code, 8'hff);
		wr(8'hd0, 8'h40);
		repeat (SETTLE + 10) @(posedge clk);
		#1;
		chk("resume", tap_code, 8'hff);
		chk("closed", {7'h00, array_open}, 8'h00);
		$display("ctrl done");
	endtask : t_ctrl
	task automatic t_refuse();
		logic [7:0] bad [5] = '{8'h40, 8'ha0, 8'he0, 8'h00, 8'hc5};
		foreach (bad[i]) begin
			wr(bad[i], 8'h33);
			chk("ignored", wiper_code, 8'hff);
		end
		host.xfer({8'hc0, 8'h33, 16'h0000}, 12, rx);
		host.finish_frame();
		chk("short", wiper_code, 8'hff);
		rd(8'h90);
		chk("ctrl kept", rd_v, CTRL_RESET);
		rd(8'h85);
		chk("unmapped echo", rd_e, 8'he5);
		chk("unmapped", rd_v, 8'h00);
		chk("idle oe", {7'h00, sdo_oe}, 8'h00);
		$display("refuse done");
	endtask : t_refuse
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict
	initial begin
		// Whole run is about 36 us of frames
		#500000;
		n_errors++;
		print_verdict();
	end
	initial begin
		rstn = 1'b0;
		od_q = 1'b0;
		sdo_last = 1'b0;
		n_errors = 0;
		tests_run = 0;
		repeat (6) @(posedge clk);
		#1;
		rstn = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		t_unarmed();
		t_wiper();
		t_ctrl();
		t_refuse();
		print_verdict();
	end
endmodule : spi_wiper_control_slave_tb
